// [pkg/dpa_defs.svh]
// constants for the direct peripheral access block
`ifndef DPA_DEFS_SVH
`define DPA_DEFS_SVH
`define TYPE_MSB 15
`define TYPE_LSB 12
`define POS_MSB 11
`define POS_LSB 8
`define DIR_BIT 7
`define BYTE_MSB 6
`define SYS_MSB 3
`define TYPE_BIN8 4'h8
`define TYPE_BIN16 4'h9
`define TYPE_BIN32 4'hA
`define TYPE_SPEC 4'hC
`define TYPE_ANALOG 4'hD
`define TYPE_PROC 4'hF
`define POS_ZERO 4'h0
`define FRAME_BASIC 4'h0
`define NUM_UNITS 16
`define IMG_BYTES 16
`define IMG_IDX_W 4
`define ZERO16 16'h0000
`define ZERO8 8'h00
`endif

// [pkg/dpa_pkg.sv]
// types for the direct peripheral access block
package dpa_pkg;
   typedef enum logic [1:0] {V_FRAME, V_BOARD, V_WIDE} variant_t;
   typedef enum {ST_IDLE, ST_BUS, ST_SCAN, ST_XCHG} state_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic wide;
      logic exchange;
      logic [15:0] addr;
      logic [15:0] wdata;
   } cpu_req_t;
   typedef struct packed {
      logic done;
      logic error;
      logic [15:0] rdata;
   } cpu_rsp_t;
   typedef struct packed {
      logic cyc;
      logic we;
      logic wide;
      logic [15:0] addr;
      logic [15:0] wdata;
   } pbus_t;
endpackage : dpa_pkg

// [verification/direct_peripheral_access_test.sv]
// self-checking bench for the direct peripheral access controller
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module direct_peripheral_access_test
   import dpa_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   variant_t variant = V_FRAME;
   logic [3:0] frame_sel = 4'h0;
   logic [15:0] unit_enable = 16'hFFFF;
   logic [15:0] unit_direct_ok = 16'h0040;
   logic [15:0] out_service = 16'hFFDF;
   logic scan_start = 1'b0;
   cpu_req_t req = '0;
   cpu_rsp_t rsp;
   logic scan_busy;
   logic [15:0] image_out;
   pbus_t pbus;
   pbus_t pb;
   logic pbus_ack;
   logic [15:0] pbus_rdata;
   logic [3:0] lat = 4'h0;
   logic cyc_q = 1'b0;
   logic [15:0] img [16] = '{default: 16'h0000};
   int fail_count = 0;
   int tests_run = 0;
   int ncyc = 0;
   integer seed = 54;
   always #5 clk = ~clk;
   direct_peripheral_access uut (.clk(clk), .rst(rst), .variant(variant),
      .frame_sel(frame_sel), .unit_enable(unit_enable), .unit_direct_ok(unit_direct_ok),
      .out_service(out_service), .scan_start(scan_start), .req(req), .rsp(rsp),
      .scan_busy(scan_busy), .image_out(image_out), .pbus(pbus), .pbus_ack(pbus_ack),
      .pbus_rdata(pbus_rdata));
   peripheral_model u_pm (.clk(clk), .rst(rst), .pbus(pbus), .pbus_ack(pbus_ack),
      .pbus_rdata(pbus_rdata), .lat(lat));
   always @(posedge clk) begin
      cyc_q <= pbus.cyc;
      if (pbus.cyc === 1'b1 && cyc_q === 1'b0) begin
         ncyc++;
         pb <= pbus;
      end
   end
   // ============================================================
   // reference model
   function automatic logic exp_err(variant_t v, logic [3:0] fr, logic ex, logic [15:0] a);
      if (ex) return v != V_WIDE || !unit_enable[a[11:8]];
      if (v == V_WIDE) return 1'b1;
      if (a[15:12] < 4'h8) return 1'b1;
      if (v == V_BOARD) return a[11:8] != 4'h0;
      if (fr != 4'h0) return 1'b1;
      return a[15:12] >= 4'hC && !unit_direct_ok[a[11:8]];
   endfunction : exp_err
   task automatic access(variant_t v, logic [3:0] fr, logic we, logic wd, logic ex,
         logic [15:0] a);
      logic [15:0] d;
      logic e;
      int n;
      int c0;
      d = $random(seed);
      c0 = ncyc;
      variant <= v;
      frame_sel <= fr;
      req <= '{valid: 1'b1, write: we, wide: wd, exchange: ex, addr: a, wdata: d};
      @(posedge clk);
      req.valid <= 1'b0;
      e = exp_err(v, fr, ex, a);
      n = 0;
      while (rsp.done !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      `CHK(n < 100, 1'b1)
      `CHK(rsp.error, e)
      if (e || (v == V_WIDE && !ex)) begin
         `CHK(ncyc, c0)
      end else begin
         `CHK(ncyc, c0 + 1)
         `CHK(pb.we, we)
         if (!ex) `CHK({pb.addr, pb.wide}, {a, wd})
         if (we && wd) `CHK(pb.wdata, ex ? img[a[11:8]] : d)
         if (!we) `CHK(rsp.rdata, wd ? a ^ 16'hA5C3 : {8'h00, a[7:0] ^ 8'hC3})
      end
      if (v == V_WIDE && !ex && we) img[a[11:8]] = d;
      repeat (4) @(posedge clk);
      `CHK(image_out, img[a[11:8]])
   endtask : access
   task automatic scan();
      int n;
      n = 0;
      scan_start <= 1'b1;
      @(posedge clk);
      scan_start <= 1'b0;
      while (scan_busy !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      while (scan_busy !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      `CHK(n < 3000, 1'b1)
      `CHK(u_pm.mem[16'h9380], img[3])
      `CHK(u_pm.wcnt.exists(16'h9580), 0)
   endtask : scan
   task automatic summarize();
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   // ============================================================
   // scenarios
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      access(V_FRAME, 4'h0, 1'b0, 1'b0, 1'b0, 16'h8100);
      lat <= 4'h7;
      access(V_FRAME, 4'h0, 1'b0, 1'b1, 1'b0, 16'h9200);
      access(V_FRAME, 4'h0, 1'b1, 1'b1, 1'b0, 16'h9283);
      access(V_FRAME, 4'h1, 1'b0, 1'b1, 1'b0, 16'h9200);
      access(V_FRAME, 4'h0, 1'b0, 1'b0, 1'b0, 16'h7000);
      access(V_FRAME, 4'h0, 1'b0, 1'b0, 1'b0, 16'hC400);
      access(V_FRAME, 4'h0, 1'b0, 1'b1, 1'b0, 16'hD600);
      lat <= 4'h0;
      access(V_BOARD, 4'h0, 1'b0, 1'b1, 1'b0, 16'h9100);
      access(V_BOARD, 4'h0, 1'b1, 1'b1, 1'b0, 16'h9080);
      access(V_BOARD, 4'h0, 1'b0, 1'b1, 1'b0, 16'hD000);
      access(V_WIDE, 4'h0, 1'b1, 1'b1, 1'b0, 16'h9380);
      unit_enable <= 16'hFFF7;
      access(V_WIDE, 4'h0, 1'b1, 1'b1, 1'b1, 16'h9380);
      unit_enable <= 16'hFFFF;
      access(V_WIDE, 4'h0, 1'b1, 1'b1, 1'b1, 16'h9380);
      access(V_WIDE, 4'h0, 1'b0, 1'b1, 1'b1, 16'h9300);
      scan();
      access(V_FRAME, 4'h0, 1'b1, 1'b1, 1'b0, 16'h9380);
      scan();
      summarize();
   end
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
endmodule : direct_peripheral_access_test

// [verification/peripheral_model.sv]
// behavioural peripheral unit answering bus cycles on the backplane
`timescale 1ns/1ps
module peripheral_model
   import dpa_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // backplane bus
   input wire pbus_t pbus,
   output logic pbus_ack = 1'b0,
   output logic [15:0] pbus_rdata = 16'h0000,
   // answer delay in cycles
   input wire logic [3:0] lat
);
   logic [15:0] mem [logic [15:0]];
   int wcnt [logic [15:0]];
   logic [3:0] cnt = 4'h0;
   // ============================================================
   // answer
   always @(posedge clk) begin
      if (rst) begin
         pbus_ack <= 1'b0;
         cnt <= 4'h0;
      end else if (pbus.cyc && !pbus_ack) begin
         if (cnt < lat) begin
            cnt <= cnt + 4'h1;
         end else begin
            pbus_ack <= 1'b1;
            if (pbus.we) begin
               mem[pbus.addr] = pbus.wdata;
               wcnt[pbus.addr]++;
            end else begin
               pbus_rdata <= mem.exists(pbus.addr) ? mem[pbus.addr] : pbus.addr ^ 16'hA5C3;
            end
         end
      end else if (!pbus.cyc && pbus_ack) begin
         pbus_ack <= 1'b0;
         cnt <= 4'h0;
         // released data turns useless so stale reads are caught
         pbus_rdata <= ~pbus_rdata;
      end
   end
endmodule : peripheral_model

// [verilog/direct_peripheral_access.sv]
// direct peripheral access controller: decode, bus cycles, image scan and exchange
`timescale 1ns/1ps
`include "dpa_defs.svh"
// ============================================================
module direct_peripheral_access
   import dpa_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration
   input wire variant_t variant,
   input wire logic [3:0] frame_sel,
   input wire logic [`NUM_UNITS-1:0] unit_enable,
   input wire logic [`NUM_UNITS-1:0] unit_direct_ok,
   input wire logic [`NUM_UNITS-1:0] out_service,
   input wire logic scan_start,
   // processor side
   input wire cpu_req_t req,
   output cpu_rsp_t rsp,
   output logic scan_busy,
   output logic [15:0] image_out,
   // peripheral bus
   output pbus_t pbus,
   input wire logic pbus_ack,
   input wire logic [15:0] pbus_rdata
);
   typedef struct packed {
      state_t st;
      cpu_rsp_t rsp;
      pbus_t bus;
      logic busy;
      logic [`IMG_IDX_W-1:0] unit;
      logic scan_out;
      logic scan_end;
      logic [15:0] img_o;
      logic ack_s1;
      logic ack_s2;
      logic [15:0] rd_s1;
      logic [15:0] rd_s2;
   } regs_t;
   regs_t r_ff, nxt_r;
   logic [15:0] img_in_ff [`IMG_BYTES];
   logic [15:0] img_out_ff [`IMG_BYTES];
   logic img_we_in, img_we_out;
   logic [`IMG_IDX_W-1:0] img_idx;
   logic [15:0] img_wdata;

   // ============================================================
   // address check
   function automatic logic addr_ok(input variant_t v, input logic [15:0] a,
                                    input logic [3:0] fr, input logic dok);
      logic [3:0] ty;
      ty = a[`TYPE_MSB:`TYPE_LSB];
      addr_ok = 1'b0;
      if (v == V_WIDE) begin
         addr_ok = 1'b0;
      end else if (ty[`SYS_MSB] == 1'b0) begin
         addr_ok = 1'b0;
      end else if (v == V_BOARD) begin
         addr_ok = (ty == `TYPE_BIN8 || ty == `TYPE_BIN16 || ty == `TYPE_BIN32 ||
                    ty == `TYPE_ANALOG) &&
                   a[`POS_MSB:`POS_LSB] == `POS_ZERO;
      end else if (fr == `FRAME_BASIC) begin
         if (ty == `TYPE_BIN8 || ty == `TYPE_BIN16 || ty == `TYPE_BIN32) begin
            addr_ok = 1'b1;
         end else if (ty == `TYPE_SPEC || ty == `TYPE_ANALOG || ty == `TYPE_PROC) begin
            addr_ok = dok;
         end
      end
   endfunction : addr_ok

   logic [`IMG_IDX_W-1:0] req_unit;
   assign req_unit = req.addr[`POS_MSB:`POS_LSB];

   // ============================================================
   // next state
   always_comb begin
      nxt_r = r_ff;
      nxt_r.rsp.done = 1'b0;
      nxt_r.rsp.error = 1'b0;
      nxt_r.ack_s1 = pbus_ack;
      nxt_r.ack_s2 = r_ff.ack_s1;
      nxt_r.rd_s1 = pbus_rdata;
      nxt_r.rd_s2 = r_ff.rd_s1;
      img_we_in = 1'b0;
      img_we_out = 1'b0;
      img_idx = r_ff.unit;
      img_wdata = r_ff.rd_s2;
      case (r_ff.st)
         ST_IDLE: begin
            if (scan_start) begin
               nxt_r.st = ST_SCAN;
               nxt_r.busy = 1'b1;
               nxt_r.unit = '0;
               nxt_r.scan_out = 1'b0;
            end else if (req.valid && req.exchange) begin
               nxt_r.unit = req_unit;
               nxt_r.scan_out = req.write;
               if (variant == V_WIDE && unit_enable[req_unit]) begin
                  nxt_r.st = ST_XCHG;
                  nxt_r.bus.cyc = 1'b1;
                  nxt_r.bus.we = req.write;
                  nxt_r.bus.wide = 1'b1;
                  nxt_r.bus.addr = {req.addr[`TYPE_MSB:`POS_LSB], req.write,
                                    req.addr[`BYTE_MSB:0]};
                  nxt_r.bus.wdata = img_out_ff[req_unit];
               end else begin
                  nxt_r.rsp.done = 1'b1;
                  nxt_r.rsp.error = 1'b1;
               end
            end else if (req.valid) begin
               if (addr_ok(variant, req.addr, frame_sel, unit_direct_ok[req_unit])) begin
                  nxt_r.st = ST_BUS;
                  nxt_r.bus.cyc = 1'b1;
                  nxt_r.bus.we = req.write;
                  nxt_r.bus.wide = req.wide;
                  nxt_r.bus.addr = req.addr;
                  nxt_r.bus.wdata = req.wdata;
               end else begin
                  nxt_r.rsp.done = 1'b1;
                  nxt_r.rsp.error = 1'b1;
               end
            end
         end
         ST_BUS: begin
            // image deliberately untouched here
            if (!r_ff.bus.cyc) begin
               // stay until the synchronised ack has fallen, else the next
               // transfer would take the old ack as its own
               if (!r_ff.ack_s2) begin
                  nxt_r.st = ST_IDLE;
               end
            end else if (r_ff.ack_s2) begin
               nxt_r.bus.cyc = 1'b0;
               nxt_r.rsp.done = 1'b1;
               nxt_r.rsp.rdata = r_ff.bus.wide ? r_ff.rd_s2 : {`ZERO8, r_ff.rd_s2[7:0]};
            end
         end
         ST_XCHG: begin
            if (!r_ff.bus.cyc) begin
               if (!r_ff.ack_s2) begin
                  nxt_r.st = ST_IDLE;
               end
            end else if (r_ff.ack_s2) begin
               nxt_r.bus.cyc = 1'b0;
               nxt_r.rsp.done = 1'b1;
               img_we_in = !r_ff.scan_out; // image stays linked
               nxt_r.rsp.rdata = r_ff.scan_out ? img_out_ff[r_ff.unit] : r_ff.rd_s2;
            end
         end
         ST_SCAN: begin
            if (!r_ff.bus.cyc && !r_ff.ack_s2) begin
               if (r_ff.scan_end) begin
                  nxt_r.st = ST_IDLE;
                  nxt_r.busy = 1'b0;
                  nxt_r.scan_end = 1'b0;
               end else if (r_ff.scan_out && !out_service[r_ff.unit]) begin
                  // unit left to direct writes: no output cycle at all
                  nxt_r.unit = r_ff.unit + 1'b1;
                  nxt_r.scan_end = (r_ff.unit == `IMG_IDX_W'(`NUM_UNITS-1));
               end else begin
                  nxt_r.bus.cyc = 1'b1;
                  nxt_r.bus.we = r_ff.scan_out;
                  nxt_r.bus.wide = 1'b1;
                  nxt_r.bus.addr = {`TYPE_BIN16, r_ff.unit, r_ff.scan_out, 7'h00};
                  nxt_r.bus.wdata = img_out_ff[r_ff.unit];
               end
            end else if (r_ff.bus.cyc && r_ff.ack_s2) begin
               nxt_r.bus.cyc = 1'b0;
               img_we_in = !r_ff.scan_out;
               nxt_r.unit = r_ff.unit + 1'b1;
               if (r_ff.unit == `IMG_IDX_W'(`NUM_UNITS-1)) begin
                  // input pass done: start outputs; output pass done: finish
                  nxt_r.scan_end = r_ff.scan_out;
                  nxt_r.scan_out = 1'b1;
               end
            end
         end
         default: nxt_r.st = ST_IDLE;
      endcase
      nxt_r.img_o = img_out_ff[req_unit];
      if (req.valid && !req.exchange && r_ff.st == ST_IDLE && !scan_start &&
          variant == V_WIDE && req.write) begin
         img_we_out = 1'b1; // program-side image write for the exchange model
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r_ff <= '{st: ST_IDLE, rsp: '0, bus: '0, busy: 1'b0, unit: '0,
                   scan_out: 1'b0, scan_end: 1'b0, img_o: `ZERO16, ack_s1: 1'b0,
                   ack_s2: 1'b0,
                   rd_s1: `ZERO16, rd_s2: `ZERO16};
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ============================================================
   // image memories: input image written only by scan and exchange, output image only by program-side writes
   always_ff @(posedge clk) begin
      if (rst) begin
         // cleared so that a scan never drives unknown words onto the bus
         for (int i = 0; i < `IMG_BYTES; i++) begin
            img_in_ff[i] <= `ZERO16;
            img_out_ff[i] <= `ZERO16;
         end
      end else begin
         if (img_we_in) begin
            img_in_ff[img_idx] <= img_wdata;
         end
         if (img_we_out) begin
            img_out_ff[req_unit] <= req.wdata;
         end
      end
   end

   assign rsp = r_ff.rsp;
   assign pbus = r_ff.bus;
   assign scan_busy = r_ff.busy;
   assign image_out = r_ff.img_o;

   // ============================================================
   // checks
   a_bus_no_image: assert property (@(posedge clk) disable iff (rst)
      r_ff.st == ST_BUS |-> !img_we_in) else $error("direct access wrote image");
   a_wide_no_phys: assert property (@(posedge clk) disable iff (rst)
      (r_ff.st == ST_IDLE && req.valid && !req.exchange && !scan_start &&
       variant == V_WIDE) |=> rsp.error) else $error("physical access in wide variant");
   a_sys_reject: assert property (@(posedge clk) disable iff (rst)
      (r_ff.st == ST_IDLE && req.valid && !scan_start && !req.exchange &&
       !req.addr[15]) |=> rsp.done && rsp.error) else $error("system type accepted");
   a_frame_zero: assert property (@(posedge clk) disable iff (rst)
      (r_ff.st == ST_IDLE && req.valid && !scan_start && !req.exchange &&
       variant == V_FRAME && frame_sel != 4'h0) |=> rsp.error) else $error("frame not 0");
   a_board_pos: assert property (@(posedge clk) disable iff (rst)
      (r_ff.st == ST_IDLE && req.valid && !scan_start && !req.exchange &&
       variant == V_BOARD && req.addr[11:8] != 4'h0) |=> rsp.error) else $error("board pos");
   a_xchg_enable: assert property (@(posedge clk) disable iff (rst)
      (r_ff.st == ST_IDLE && req.valid && !scan_start && req.exchange &&
       !unit_enable[req.addr[11:8]]) |=> rsp.error && r_ff.st == ST_IDLE)
      else $error("exchange on disabled unit");
   a_bus_addr: assert property (@(posedge clk) disable iff (rst)
      (r_ff.st == ST_IDLE && req.valid && !scan_start && !req.exchange &&
       addr_ok(variant, req.addr, frame_sel, unit_direct_ok[req.addr[11:8]]))
      |=> pbus.cyc && pbus.addr == $past(req.addr)) else $error("bus addr");
   a_scan_write: assert property (@(posedge clk) disable iff (rst)
      img_we_in |-> (r_ff.st == ST_SCAN || r_ff.st == ST_XCHG)) else $error("image write");
   a_scan_input: assert property (@(posedge clk) disable iff (rst)
      (r_ff.st == ST_SCAN && r_ff.bus.cyc && r_ff.ack_s2 && !r_ff.scan_out)
      |=> img_in_ff[$past(r_ff.unit)] == $past(r_ff.rd_s2)) else $error("scan input image");
   a_xchg_link: assert property (@(posedge clk) disable iff (rst)
      (r_ff.st == ST_XCHG && r_ff.bus.cyc && r_ff.ack_s2 && !r_ff.scan_out)
      |=> img_in_ff[$past(r_ff.unit)] == rsp.rdata) else $error("exchange image link");
   c_direct: cover property (@(posedge clk) r_ff.st == ST_BUS && r_ff.ack_s2);
   c_scan: cover property (@(posedge clk) r_ff.busy ##1 !r_ff.busy);
   c_xchg: cover property (@(posedge clk) r_ff.st == ST_XCHG && r_ff.ack_s2);
endmodule : direct_peripheral_access
